/* File: logic/dacfg_defs.vh */
// Purpose: offsets, field positions, masks and reset values of the
//          display, audio and equalizer configuration registers
// Assumes: 8-bit registers on an 8-bit register address
// Notes:   definitions only
`ifndef DACFG_DEFS_VH
`define DACFG_DEFS_VH

// register offsets
`define DACFG_OFS_DITHER 8'h29
`define DACFG_OFS_AUDIO 8'h2b
`define DACFG_OFS_EQ 8'h35
`define DACFG_OFS_PGCLK 8'h39

// reset values
`define DACFG_RST_DITHER 8'h00
`define DACFG_RST_AUDIO 8'h00
`define DACFG_RST_EQ 8'h00
`define DACFG_RST_PGCLK 8'h00

// writable bits; the rest are reserved and read as zero
`define DACFG_MASK_DITHER 8'hff
`define DACFG_MASK_AUDIO 8'hc1
`define DACFG_MASK_EQ 8'h70
`define DACFG_MASK_PGCLK 8'h02

// display timing and dither control fields
`define DACFG_BIT_SYNC_MODE 7
`define DACFG_BIT_HSYNC_POL 6
`define DACFG_BIT_VSYNC_POL 5
`define DACFG_BIT_VALID_POL 4
`define DACFG_BIT_DITHER_TWO 3
`define DACFG_BIT_DITHER_ONE 2
`define DACFG_BIT_FINE_TWO_OFF 1
`define DACFG_BIT_FINE_ONE_OFF 0

// audio serial control fields
`define DACFG_BIT_PLL_OVERRIDE 7
`define DACFG_BIT_PLL_OFF 6
`define DACFG_BIT_RISING_EDGE 0

// equalizer control fields
`define DACFG_BIT_EQ_RESTART 6
`define DACFG_BIT_LONG_CABLE_MODE_OVERRIDE 5
`define DACFG_BIT_LONG_CABLE_MODE 4

// pattern generator clock field
`define DACFG_BIT_TEST_PATTERN_INTERNAL_CLOCK 1

// floor width and the floor used outside long-cable mode
`define DACFG_FLOOR_W 4
`define DACFG_FLOOR_DEFAULT 4'h0

`endif

/* File: logic/dacfg_eq_src.v */
// Purpose: resolves long-cable mode source and the equalizer floor
// Assumes: strap level is caught by the parent after reset release
// Notes:   one cycle of latency on every output
`timescale 1ns/1ns
`include "dacfg_defs.vh"
`default_nettype none
module dacfg_eq_src (
    input wire ref_clk,
    input wire rst_b,
    input wire lcblOverride,
    input wire lcblReg,
    input wire lcblStrap,
    input wire [`DACFG_FLOOR_W-1:0] floorIn,
    output reg longCableMode_ff,
    output reg [`DACFG_FLOOR_W-1:0] eqFloor_ff
);
    wire longCable;
    assign longCable = lcblOverride ? lcblReg : lcblStrap;

    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            longCableMode_ff <= 1'b0;
            eqFloor_ff <= `DACFG_FLOOR_DEFAULT;
        end
        else
        begin
            longCableMode_ff <= longCable;
            eqFloor_ff <= longCable ? floorIn : `DACFG_FLOOR_DEFAULT;
        end
    end
endmodule // dacfg_eq_src
`default_nettype wire

/* File: logic/dacfg_regs.v */
// Purpose: display timing, dither, audio serial, equalizer and pattern
//          clock configuration registers with their decoded controls
// Assumes: the serial control bus slave presents one-cycle read and write
//          strobes with an 8-bit offset, synchronous to ref_clk
// Notes:   read data appears one edge after the read strobe and holds
//
// Behaviour
// - bit 7 at 0x29 picks sync timing when 1 and pixel-valid-only timing when 0.
// - bit 6 at 0x29 makes the horizontal sync output active low when 1.
// - bit 5 at 0x29 makes the vertical sync output active low when 1.
// - bit 4 at 0x29 makes pixel_valid active low when 1.
// - bits 3 and 2 at 0x29 enable dither stages two and one, both off at reset.
// - bits 1 and 0 at 0x29 disable fine dither stages two and one, both on at reset.
// - bit 7 at 0x2b overrides the automatic audio PLL control when 1.
// - bit 6 at 0x2b turns the audio PLL and its jitter cleaning off when 1.
// - bit 0 at 0x2b strobes serial audio data on the rising edge when 1, else falling.
// - bit 6 at 0x35 holds the equalizer in restart from its floor while it is 1.
// - the restart bit never clears itself; software writes 1 then 0.
// - bit 5 at 0x35 takes long-cable mode from the register when 1, else from the strap.
// - bit 4 at 0x35 sets long-cable mode under register control, which uses the stored floor.
// - bit 1 at 0x39 selects the internal pattern clock when 1, external when 0.
// - the long-cable floor is bits 3:0 of the min/max register at 0x45.
`timescale 1ns/1ns
`include "dacfg_defs.vh"
`default_nettype none
module dacfg_regs (
    input wire ref_clk,
    input wire rst_b,
    input wire [7:0] regAddr,
    input wire regWrEn,
    input wire [7:0] regWrData,
    input wire regRdEn,
    output reg [7:0] regRdData_ff,
    input wire longCableStrap,
    input wire [`DACFG_FLOOR_W-1:0] eqFloorReg,
    input wire rawHorizontalSync,
    input wire rawVerticalSync,
    input wire rawPixelValid,
    output wire horizontalSyncOut,
    output wire verticalSyncOut,
    output wire pixelValidOut,
    output reg syncTimingMode_ff,
    output reg ditherStageTwoEn_ff,
    output reg ditherStageOneEn_ff,
    output reg fineDitherStageTwoEn_ff,
    output reg fineDitherStageOneEn_ff,
    output reg audioPllOverride_ff,
    output reg audioPllRun_ff,
    output reg audioRisingEdge_ff,
    output reg eqRestart_ff,
    output wire longCableMode,
    output wire [`DACFG_FLOOR_W-1:0] eqFloor,
    output reg testPatternInternalClock_ff
);
    // stored register images
    reg [7:0] ditherCtrl_ff;
    reg [7:0] audioCtrl_ff;
    reg [7:0] eqCtrl_ff;
    reg [7:0] pgClkCtrl_ff;
    reg [7:0] nxt_regRdData;

    // strap capture
    reg strapTaken_ff;
    reg strapLevel_ff;

    // write decode
    wire wrDither;
    wire wrAudio;
    wire wrEq;
    wire wrPgClk;

    assign wrDither = regWrEn & (regAddr == `DACFG_OFS_DITHER);
    assign wrAudio = regWrEn & (regAddr == `DACFG_OFS_AUDIO);
    assign wrEq = regWrEn & (regAddr == `DACFG_OFS_EQ);
    assign wrPgClk = regWrEn & (regAddr == `DACFG_OFS_PGCLK);

    // display timing and dither register
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ditherCtrl_ff <= `DACFG_RST_DITHER;
        end
        else if (wrDither)
        begin
            ditherCtrl_ff <= regWrData & `DACFG_MASK_DITHER;
        end
    end

    // audio serial register
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            audioCtrl_ff <= `DACFG_RST_AUDIO;
        end
        else if (wrAudio)
        begin
            audioCtrl_ff <= regWrData & `DACFG_MASK_AUDIO;
        end
    end

    // equalizer control register
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            eqCtrl_ff <= `DACFG_RST_EQ;
        end
        else if (wrEq)
        begin
            eqCtrl_ff <= regWrData & `DACFG_MASK_EQ;
        end
    end

    // pattern generator clock register
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pgClkCtrl_ff <= `DACFG_RST_PGCLK;
        end
        else if (wrPgClk)
        begin
            pgClkCtrl_ff <= regWrData & `DACFG_MASK_PGCLK;
        end
    end

    // strap is sampled on the first edge after reset release, never
    // under the asynchronous reset itself, and then held until the next reset
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            strapTaken_ff <= 1'b0;
            strapLevel_ff <= 1'b0;
        end
        else if (!strapTaken_ff)
        begin
            strapTaken_ff <= 1'b1;
            strapLevel_ff <= longCableStrap;
        end
    end

    // read mux; unmapped offsets read as zero
    always @*
    begin
        nxt_regRdData = regRdData_ff;
        if (regRdEn)
        begin
            case (regAddr)
                `DACFG_OFS_DITHER:
                begin
                    nxt_regRdData = ditherCtrl_ff;
                end
                `DACFG_OFS_AUDIO:
                begin
                    nxt_regRdData = audioCtrl_ff;
                end
                `DACFG_OFS_EQ:
                begin
                    nxt_regRdData = eqCtrl_ff;
                end
                `DACFG_OFS_PGCLK:
                begin
                    nxt_regRdData = pgClkCtrl_ff;
                end
                default:
                begin
                    nxt_regRdData = 8'h00;
                end
            endcase
        end
    end

    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            regRdData_ff <= 8'h00;
        end
        else
        begin
            regRdData_ff <= nxt_regRdData;
        end
    end

    // decoded controls, each one flop behind its register image so
    // that every output leaves straight from a flop
    // timing mode select
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            syncTimingMode_ff <= 1'b0;
        end
        else
        begin
            syncTimingMode_ff <= ditherCtrl_ff[`DACFG_BIT_SYNC_MODE];
        end
    end

    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ditherStageTwoEn_ff <= 1'b0;
        end
        else
        begin
            ditherStageTwoEn_ff <= ditherCtrl_ff[`DACFG_BIT_DITHER_TWO];
        end
    end

    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ditherStageOneEn_ff <= 1'b0;
        end
        else
        begin
            ditherStageOneEn_ff <= ditherCtrl_ff[`DACFG_BIT_DITHER_ONE];
        end
    end

    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fineDitherStageTwoEn_ff <= 1'b1;
        end
        else
        begin
            fineDitherStageTwoEn_ff <= ~ditherCtrl_ff[`DACFG_BIT_FINE_TWO_OFF];
        end
    end

    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fineDitherStageOneEn_ff <= 1'b1;
        end
        else
        begin
            fineDitherStageOneEn_ff <= ~ditherCtrl_ff[`DACFG_BIT_FINE_ONE_OFF];
        end
    end

    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            audioPllOverride_ff <= 1'b0;
        end
        else
        begin
            audioPllOverride_ff <= audioCtrl_ff[`DACFG_BIT_PLL_OVERRIDE];
        end
    end

    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            audioPllRun_ff <= 1'b1;
        end
        else
        begin
            audioPllRun_ff <= ~audioCtrl_ff[`DACFG_BIT_PLL_OFF];
        end
    end

    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            audioRisingEdge_ff <= 1'b0;
        end
        else
        begin
            audioRisingEdge_ff <= audioCtrl_ff[`DACFG_BIT_RISING_EDGE];
        end
    end

    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            eqRestart_ff <= 1'b0;
        end
        else
        begin
            eqRestart_ff <= eqCtrl_ff[`DACFG_BIT_EQ_RESTART];
        end
    end

    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            testPatternInternalClock_ff <= 1'b0;
        end
        else
        begin
            testPatternInternalClock_ff <= pgClkCtrl_ff[`DACFG_BIT_TEST_PATTERN_INTERNAL_CLOCK];
        end
    end

    // sync polarity uses the register image directly, not the decoded
    // copy, to keep the pixel path at a single cycle of latency
    dacfg_sync_pol uSyncPol (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .syncMode(ditherCtrl_ff[`DACFG_BIT_SYNC_MODE]),
        .hsyncActiveLow(ditherCtrl_ff[`DACFG_BIT_HSYNC_POL]),
        .vsyncActiveLow(ditherCtrl_ff[`DACFG_BIT_VSYNC_POL]),
        .validActiveLow(ditherCtrl_ff[`DACFG_BIT_VALID_POL]),
        .rawHorizontalSync(rawHorizontalSync),
        .rawVerticalSync(rawVerticalSync),
        .rawPixelValid(rawPixelValid),
        .horizontalSyncOut_ff(horizontalSyncOut),
        .verticalSyncOut_ff(verticalSyncOut),
        .pixelValidOut_ff(pixelValidOut)
    );

    // until the strap is caught the equalizer sees short-cable mode
    dacfg_eq_src uEqSrc (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .lcblOverride(eqCtrl_ff[`DACFG_BIT_LONG_CABLE_MODE_OVERRIDE]),
        .lcblReg(eqCtrl_ff[`DACFG_BIT_LONG_CABLE_MODE]),
        .lcblStrap(strapLevel_ff),
        .floorIn(eqFloorReg),
        .longCableMode_ff(longCableMode),
        .eqFloor_ff(eqFloor)
    );
endmodule // dacfg_regs
`default_nettype wire

/* File: logic/dacfg_sync_pol.v */
// Purpose: applies timing mode and output polarities to pixel_valid and syncs
// Assumes: raw inputs are active high and synchronous to ref_clk
// Notes:   one cycle of latency on every output
`timescale 1ns/1ns
`default_nettype none
module dacfg_sync_pol (
    input wire ref_clk,
    input wire rst_b,
    input wire syncMode,
    input wire hsyncActiveLow,
    input wire vsyncActiveLow,
    input wire validActiveLow,
    input wire rawHorizontalSync,
    input wire rawVerticalSync,
    input wire rawPixelValid,
    output reg horizontalSyncOut_ff,
    output reg verticalSyncOut_ff,
    output reg pixelValidOut_ff
);
    // in pixel-valid-only mode the syncs rest at their inactive level
    wire hsyncLevel;
    wire vsyncLevel;
    assign hsyncLevel = syncMode & rawHorizontalSync;
    assign vsyncLevel = syncMode & rawVerticalSync;

    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            // polarity bits reset to active high, so idle is low
            horizontalSyncOut_ff <= 1'b0;
            verticalSyncOut_ff <= 1'b0;
            pixelValidOut_ff <= 1'b0;
        end
        else
        begin
            horizontalSyncOut_ff <= hsyncLevel ^ hsyncActiveLow;
            verticalSyncOut_ff <= vsyncLevel ^ vsyncActiveLow;
            pixelValidOut_ff <= rawPixelValid ^ validActiveLow;
        end
    end
endmodule // dacfg_sync_pol
`default_nettype wire

/* File: verification/dacfg_regs_monitor.sv */
// Purpose: concurrent checks on the configuration register ports
// Assumes: one ref_clk domain, rst_b asynchronous and active low
// Notes: bound to every dacfg_regs instance
`timescale 1ns/1ns
`default_nettype none
module dacfg_regs_monitor (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic regRdEn,
    input wire logic [7:0] regRdData_ff,
    input wire logic syncTimingMode_ff,
    input wire logic ditherStageTwoEn_ff,
    input wire logic fineDitherStageOneEn_ff,
    input wire logic audioPllRun_ff,
    input wire logic audioRisingEdge_ff,
    input wire logic eqRestart_ff,
    input wire logic longCableMode,
    input wire logic [3:0] eqFloor,
    input wire logic testPatternInternalClock_ff
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    wire logic wrDith = regWrEn && regAddr == 8'h29;
    wire logic wrAud = regWrEn && regAddr == 8'h2b;
    wire logic wrEq = regWrEn && regAddr == 8'h35;
    wire logic wrPg = regWrEn && regAddr == 8'h39;
    wire logic mapped = regAddr == 8'h29 || regAddr == 8'h2b ||
        regAddr == 8'h35 || regAddr == 8'h39;
    wire logic rdOdd = regRdEn && !mapped;

    a_unmapped_read_zero: assert property (rdOdd |=> regRdData_ff == 8'h00)
        else $error("unmapped read not zero");
    a_read_data_holds: assert property (!regRdEn |=> $stable(regRdData_ff))
        else $error("read data moved without a read");
    a_sync_mode_sel: assert property (wrDith |-> ##2
        syncTimingMode_ff == $past(regWrData[7], 2))
        else $error("timing mode wrong");
    a_dither_two_en: assert property (wrDith |-> ##2
        ditherStageTwoEn_ff == $past(regWrData[3], 2))
        else $error("dither stage two wrong");
    a_fine_one_inv: assert property (wrDith |-> ##2
        fineDitherStageOneEn_ff != $past(regWrData[0], 2))
        else $error("fine dither one sense wrong");
    a_pll_run_inv: assert property (wrAud |-> ##2 audioPllRun_ff != $past(regWrData[6], 2))
        else $error("audio pll run wrong");
    a_strobe_edge_sel: assert property (wrAud |-> ##2
        audioRisingEdge_ff == $past(regWrData[0], 2))
        else $error("strobe edge wrong");
    a_restart_follows: assert property (wrEq |-> ##2 eqRestart_ff == $past(regWrData[6], 2))
        else $error("restart bit wrong");
    a_restart_no_selfclear: assert property ($fell(eqRestart_ff) |->
        $past(wrEq && !regWrData[6], 2))
        else $error("restart cleared by itself");
    a_cable_by_reg: assert property (wrEq && regWrData[5] |-> ##2
        longCableMode == $past(regWrData[4], 2))
        else $error("long cable mode wrong");
    a_floor_idle_zero: assert property (!longCableMode |-> eqFloor == 4'h0)
        else $error("floor not zero outside long cable");
    a_pattern_clock_sel: assert property (wrPg |-> ##2
        testPatternInternalClock_ff == $past(regWrData[1], 2))
        else $error("pattern clock select wrong");

    cover property (wrEq && regWrData[6]);
    cover property (rdOdd);
    cover property (longCableMode && eqFloor != 4'h0);
endmodule // dacfg_regs_monitor

bind dacfg_regs dacfg_regs_monitor mon (.ref_clk(ref_clk), .rst_b(rst_b), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData_ff(regRdData_ff),
    .syncTimingMode_ff(syncTimingMode_ff), .ditherStageTwoEn_ff(ditherStageTwoEn_ff),
    .fineDitherStageOneEn_ff(fineDitherStageOneEn_ff), .audioPllRun_ff(audioPllRun_ff),
    .audioRisingEdge_ff(audioRisingEdge_ff), .eqRestart_ff(eqRestart_ff),
    .longCableMode(longCableMode), .eqFloor(eqFloor),
    .testPatternInternalClock_ff(testPatternInternalClock_ff));
`default_nettype wire

/* File: verification/dacfg_regs_tb_top.sv */
// Purpose: self-checking bench for the configuration registers
// Assumes: strobes driven on the falling edge, one access per task call
// Notes: strap high, then low after a second reset, so the pin path of long-cable mode is seen
`timescale 1ns/1ns
`default_nettype none
module dacfg_regs_tb_top;
    logic ref_clk, rst_b, regWrEn, regRdEn, longCableStrap, rawHs, rawVs, rawPv;
    logic [7:0] regAddr, regWrData, rdData;
    logic [3:0] eqFloorReg, eqFloor;
    logic hsOut, vsOut, pvOut, syncMode, dTwo, dOne, fTwo, fOne;
    logic pllOvr, pllRun, risEdge, eqRst, lcMode, pgClk;
    int mismatches = 0;
    int cmp_count = 0;
    logic [7:0] ofs [4] = '{8'h29, 8'h2b, 8'h35, 8'h39};
    logic [7:0] msk [4] = '{8'hff, 8'hc1, 8'h70, 8'h02};

    dacfg_regs dut (.ref_clk(ref_clk), .rst_b(rst_b), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn), .regRdData_ff(rdData),
        .longCableStrap(longCableStrap), .eqFloorReg(eqFloorReg), .rawHorizontalSync(rawHs),
        .rawVerticalSync(rawVs), .rawPixelValid(rawPv), .horizontalSyncOut(hsOut),
        .verticalSyncOut(vsOut), .pixelValidOut(pvOut), .syncTimingMode_ff(syncMode),
        .ditherStageTwoEn_ff(dTwo), .ditherStageOneEn_ff(dOne), .fineDitherStageTwoEn_ff(fTwo),
        .fineDitherStageOneEn_ff(fOne), .audioPllOverride_ff(pllOvr), .audioPllRun_ff(pllRun),
        .audioRisingEdge_ff(risEdge), .eqRestart_ff(eqRst), .longCableMode(lcMode),
        .eqFloor(eqFloor), .testPatternInternalClock_ff(pgClk));

    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // entered and left on a falling edge, so one rising edge takes the strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        tick(1);
        regWrEn = 1'b0;
        // idle edge so a following call never re-raises the strobe in one step
        tick(1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        regAddr = a;
        regRdEn = 1'b1;
        tick(1);
        regRdEn = 1'b0;
        check($sformatf("read %h", a), rdData, exp);
        tick(1);
    endtask

    initial
    begin
        tick(5000);
        mismatches++;
        print_verdict();
    end

    initial
    begin
        rst_b = 1'b0;
        {regWrEn, regRdEn, rawHs, rawVs, rawPv} = 5'h00;
        regAddr = 8'h00;
        regWrData = 8'h00;
        longCableStrap = 1'b1;
        eqFloorReg = 4'ha;
        tick(16);
        rst_b = 1'b1;
        tick(3);
        check("reset controls", {syncMode, dTwo, dOne, fTwo, fOne, pllOvr, pllRun, risEdge},
            8'h1a);
        check("reset eq", {eqRst, lcMode, eqFloor, pgClk}, {1'b0, 1'b1, 4'ha, 1'b0});
        for (int i = 0; i < 4; i++)
        begin
            rd(ofs[i], 8'h00);
            wr(ofs[i], 8'hff);
            rd(ofs[i], msk[i]);
        end
        tick(2);
        check("set controls", {syncMode, dTwo, dOne, fTwo, fOne, pllOvr, pllRun, risEdge},
            8'he5);
        check("set eq", {eqRst, lcMode, eqFloor, pgClk}, {1'b1, 1'b1, 4'ha, 1'b1});
        wr(8'h2a, 8'hff);
        rd(8'h2a, 8'h00);
        rd(8'h45, 8'h00);
        rd(8'h2b, 8'hc1);
        // restart must survive idle time untouched
        tick(20);
        check("restart held", eqRst, 1'b1);
        wr(8'h35, 8'h20);
        tick(3);
        check("reg cable off", {eqRst, lcMode, eqFloor}, 6'h00);
        wr(8'h35, 8'h10);
        eqFloorReg = 4'h5;
        tick(3);
        check("strap cable", {lcMode, eqFloor}, 5'h15);
        for (int m = 0; m < 16; m++)
        begin
            wr(8'h29, {m[3:0], 4'h0});
            for (int r = 0; r < 8; r++)
            begin
                {rawHs, rawVs, rawPv} = r[2:0];
                tick(3);
                check("pixel path", {hsOut, vsOut, pvOut},
                    {(m[3] & r[2]) ^ m[2], (m[3] & r[1]) ^ m[1], r[0] ^ m[0]});
            end
        end
        // strap low this time, so the pin path is seen at both levels
        longCableStrap = 1'b0;
        rst_b = 1'b0;
        tick(2);
        rst_b = 1'b1;
        tick(3);
        check("reset again", {syncMode, dTwo, dOne, fTwo, fOne, pllOvr, pllRun, risEdge},
            8'h1a);
        check("strap low", {lcMode, eqFloor}, 5'h00);
        rd(8'h29, 8'h00);
        print_verdict();
    end
endmodule // dacfg_regs_tb_top
`default_nettype wire
